// File: bso_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "bso_consts.svh"

// What this block does
// - power-on reset loads every register and config mirror with its preset value
// - after power-up the mirrors reload from nonvolatile memory, taking about 66 ms
// - status register shows a busy bit while that reload runs
// - power-loss flag sets on supply drop and holds until host writes 0
// - power-loss interrupt fires if enabled and the flag was clear before
// - returning to main supply is debounced for 122 us before bus access reopens
// - mode field: 00 and 10 off, 01 direct, 11 level switching
// - direct mode picks main while it exceeds backup, else backup
// - level mode picks backup only if main below and backup above threshold
// - entering backup sets switchover flag; enabled interrupt holds until flag cleared
// - host bus is isolated and held in reset while on backup power
// - external event input keeps working on backup power
// - clock output is forced low throughout backup power
// - interrupt pin keeps serving earlier configured sources on backup power
// - switchover can enable clock output once main power returns
// - with switchover off the flag reads 0 and main supply stays selected
// - first powered from backup alone, switchover stays off and backup idles
// - off to direct mode takes effect within 2 ms
// - off to level mode takes effect within 15.625 ms
// - charger enable bit and resistor field live in the backup config; default off
// - charger is forced off on backup power
module bso_ctrl #(
  parameter int unsigned PREFR_CYC = `BSO_PREFR_CYC,
  parameter int unsigned DSM_CYC = `BSO_DSM_CYC,
  parameter int unsigned LSM_CYC = `BSO_LSM_CYC
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic vddAboveBackup,
  input wire logic vddAboveThr,
  input wire logic backupAboveThr,
  input wire logic vddPresent,
  input wire logic supplyDrop,
  input wire logic [7:0] nvmClkoutByte,
  input wire logic [7:0] nvmBackupByte,
  input wire logic eventIn,
  input wire logic otherIrq,
  output logic intN,
  output logic clkoutLow,
  output logic busOff,
  output logic chargerOn,
  output logic [1:0] chargerRes,
  output logic fastEdgeEn,
  output logic eventOut,
  output logic backupSelect,
  output logic backupStandby,
  output logic clkoutWake,
  output logic nvmBusy
);

  localparam int unsigned DEB_CYC = `BSO_DEB_CYC;

  bso_pkg::bso_state_s q;
  bso_pkg::bso_state_s d;
  bso_pkg::bso_mode_e cfgKind;
  bso_pkg::bso_mode_e effKind;
  bso_pkg::bso_mode_e nextKind;
  logic [20:0] modeTarget;
  logic wantBak;
  logic swSet;
  logic porSet;
  logic wrNow;
  logic wrStat;
  logic busOpen;

  function automatic bso_pkg::bso_mode_e modeKind(input logic [1:0] f);
    case (f)
      2'b01: modeKind = bso_pkg::MODE_DIRECT;
      2'b11: modeKind = bso_pkg::MODE_LEVEL;
      default: modeKind = bso_pkg::MODE_OFF;
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == 8'(`BSO_IDX_STATUS * 4)) || (a == 8'(`BSO_IDX_CLKCFG * 4)) ||
             (a == 8'(`BSO_IDX_BAKCFG * 4));
  endfunction

  always_comb begin
    d = q;
    cfgKind = modeKind(q.cfgBak[`BSO_BK_BSM_LO +: 2]);
    effKind = modeKind(q.effMode);
    nextKind = bso_pkg::MODE_OFF;
    modeTarget = 21'h0;
    wantBak = 1'b0;
    swSet = 1'b0;
    porSet = 1'b0;
    wrNow = 1'b0;
    wrStat = 1'b0;
    busOpen = 1'b0;

    // first stage feeds only the second
    d.syncA = {supplyDrop, vddPresent, backupAboveThr, vddAboveThr, vddAboveBackup};
    d.syncB = q.syncA;
    d.dropPrev = q.syncB[`BSO_S_DROP];

    if (q.nvmBusy) begin
      d.refreshCnt = q.refreshCnt + 21'h1;
      if (q.refreshCnt == 21'(PREFR_CYC - 1)) begin
        d.nvmBusy = 1'b0;
        d.cfgClk = nvmClkoutByte;
        d.cfgBak = nvmBackupByte;
      end
    end

    // backup-only start keeps switchover off until main has been seen
    if (q.syncB[`BSO_S_VDD_ON]) begin
      d.mainSeen = 1'b1;
    end
    modeTarget = (cfgKind == bso_pkg::MODE_DIRECT) ? 21'(DSM_CYC - 1) : 21'(LSM_CYC - 1);
    if (!q.mainSeen) begin
      d.effMode = 2'h0;
      d.modeCnt = 21'h0;
    end else if (cfgKind == bso_pkg::MODE_OFF || effKind != bso_pkg::MODE_OFF) begin
      d.effMode = q.cfgBak[`BSO_BK_BSM_LO +: 2];
      d.modeCnt = 21'h0;
    end else begin
      d.modeCnt = q.modeCnt + 21'h1;
      if (q.modeCnt >= modeTarget) begin
        d.effMode = q.cfgBak[`BSO_BK_BSM_LO +: 2];
      end
    end
    nextKind = modeKind(d.effMode);

    case (nextKind)
      bso_pkg::MODE_DIRECT: wantBak = !q.syncB[`BSO_S_VDD_GT_BAK];
      bso_pkg::MODE_LEVEL: wantBak = !q.syncB[`BSO_S_VDD_GT_THR] &&
                                     q.syncB[`BSO_S_BAK_GT_THR];
      default: wantBak = 1'b0;
    endcase

    case (q.pwr)
      bso_pkg::PWR_MAIN: begin
        if (wantBak) begin
          d.pwr = bso_pkg::PWR_BACKUP;
          swSet = 1'b1;
        end
      end
      bso_pkg::PWR_BACKUP: begin
        if (!wantBak) begin
          d.pwr = bso_pkg::PWR_DEBOUNCE;
          d.debCnt = 12'h0;
        end
      end
      bso_pkg::PWR_DEBOUNCE: begin
        // a dip during debounce restarts the whole wait
        if (wantBak) begin
          d.pwr = bso_pkg::PWR_BACKUP;
        end else if (q.debCnt == 12'(DEB_CYC - 1)) begin
          d.pwr = bso_pkg::PWR_MAIN;
          if (q.cfgClk[`BSO_CK_WAKE]) begin
            d.clkWake = 1'b1;
          end
        end else begin
          d.debCnt = q.debCnt + 12'h1;
        end
      end
      default: d.pwr = bso_pkg::PWR_MAIN;
    endcase
    if (nextKind == bso_pkg::MODE_OFF) begin
      d.pwr = bso_pkg::PWR_MAIN;
    end

    // bus: any half-done transfer is dropped when power leaves main
    busOpen = (d.pwr == bso_pkg::PWR_MAIN);
    if (!busOpen) begin
      d.awHeld = 1'b0;
      d.wHeld = 1'b0;
      d.bValid = 1'b0;
      d.rValid = 1'b0;
    end else begin
      if (s_axi_awvalid && q.awRdy) begin
        d.awHeld = 1'b1;
        d.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && q.wRdy) begin
        d.wHeld = 1'b1;
        d.wData = s_axi_wdata[7:0];
        d.wStrb0 = s_axi_wstrb[0];
      end
      if (q.bValid && s_axi_bready) begin
        d.bValid = 1'b0;
      end
      if (q.awHeld && q.wHeld && !q.bValid) begin
        wrNow = 1'b1;
        d.awHeld = 1'b0;
        d.wHeld = 1'b0;
        d.bValid = 1'b1;
        d.bResp = mapped(q.awAddr) ? `BSO_RESP_OKAY : `BSO_RESP_SLVERR;
      end
      if (q.rValid && s_axi_rready) begin
        d.rValid = 1'b0;
      end
      if (s_axi_arvalid && q.arRdy) begin
        d.rValid = 1'b1;
        d.rResp = mapped(s_axi_araddr) ? `BSO_RESP_OKAY : `BSO_RESP_SLVERR;
        d.rData = 8'h0;
        if (s_axi_araddr == 8'(`BSO_IDX_STATUS * 4)) begin
          d.rData[`BSO_ST_PLF] = q.powerLossFlag;
          d.rData[`BSO_ST_SWF] = q.swFlag;
          d.rData[`BSO_ST_BUSY] = q.nvmBusy;
        end else if (s_axi_araddr == 8'(`BSO_IDX_CLKCFG * 4)) begin
          d.rData = q.cfgClk;
        end else if (s_axi_araddr == 8'(`BSO_IDX_BAKCFG * 4)) begin
          d.rData = q.cfgBak;
        end
      end
    end

    if (wrNow && q.wStrb0) begin
      wrStat = (q.awAddr == 8'(`BSO_IDX_STATUS * 4));
      if (wrStat) begin
        if (!q.wData[`BSO_ST_PLF]) begin
          d.powerLossFlag = 1'b0;
          d.porIrqPend = 1'b0;
        end
        if (!q.wData[`BSO_ST_SWF]) begin
          d.swFlag = 1'b0;
          d.clkWake = 1'b0;
        end
      end
      // mirrors are not writable while the reload would overwrite them
      if (!q.nvmBusy && q.awAddr == 8'(`BSO_IDX_CLKCFG * 4)) begin
        d.cfgClk = q.wData;
      end
      if (!q.nvmBusy && q.awAddr == 8'(`BSO_IDX_BAKCFG * 4)) begin
        d.cfgBak = q.wData;
      end
    end

    // hardware sets land after host clears so a coincident event survives
    porSet = q.syncB[`BSO_S_DROP] && !q.dropPrev;
    if (porSet) begin
      d.powerLossFlag = 1'b1;
      if (!q.powerLossFlag && q.cfgClk[`BSO_CK_POWER_LOSS_IRQ_ENABLE]) begin
        d.porIrqPend = 1'b1;
      end
    end
    if (swSet) begin
      d.swFlag = 1'b1;
    end
    if (nextKind == bso_pkg::MODE_OFF) begin
      d.swFlag = 1'b0;
    end

    d.awRdy = busOpen && !d.awHeld && !d.bValid;
    d.wRdy = busOpen && !d.wHeld && !d.bValid;
    d.arRdy = busOpen && !d.rValid;
    d.intN = !(q.porIrqPend || (q.swFlag && q.cfgBak[`BSO_BK_SWITCHOVER_IRQ_ENABLE]) ||
               otherIrq);
    d.clkLow = (d.pwr != bso_pkg::PWR_MAIN);
    d.busOff = (d.pwr != bso_pkg::PWR_MAIN);
    d.chgOn = (d.pwr == bso_pkg::PWR_MAIN) && d.cfgBak[`BSO_BK_TCE];
    d.evtOut = eventIn;
    d.bakSel = (d.pwr != bso_pkg::PWR_MAIN);
    d.standby = (nextKind == bso_pkg::MODE_OFF);
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      q <= '0;
      q.nvmBusy <= 1'b1;
      q.cfgClk <= `BSO_RST_CLKCFG;
      q.cfgBak <= `BSO_RST_BAKCFG;
      q.powerLossFlag <= 1'b1;
      q.pwr <= bso_pkg::PWR_MAIN;
      q.intN <= 1'b1;
      q.standby <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = q.awRdy;
  assign s_axi_wready = q.wRdy;
  assign s_axi_bvalid = q.bValid;
  assign s_axi_bresp = q.bResp;
  assign s_axi_arready = q.arRdy;
  assign s_axi_rvalid = q.rValid;
  assign s_axi_rresp = q.rResp;
  assign s_axi_rdata = {24'h0, q.rData};
  assign intN = q.intN;
  assign clkoutLow = q.clkLow;
  assign busOff = q.busOff;
  assign chargerOn = q.chgOn;
  assign chargerRes = q.cfgBak[`BSO_BK_TCR_LO +: 2];
  assign fastEdgeEn = q.cfgBak[`BSO_BK_FAST_EDGE_DETECT_ENABLE];
  assign eventOut = q.evtOut;
  assign backupSelect = q.bakSel;
  assign backupStandby = q.standby;
  assign clkoutWake = q.clkWake;
  assign nvmBusy = q.nvmBusy;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  refresh_end_a: assert property (
    q.nvmBusy && q.refreshCnt == 21'(PREFR_CYC - 1) |=> !q.nvmBusy && q.cfgBak == $past(nvmBackupByte)
  ) else $error("refresh did not finish on time");

  flag_hold_a: assert property (
    $fell(q.powerLossFlag) |-> $past(wrStat) && !$past(q.wData[`BSO_ST_PLF])
  ) else $error("power-loss flag cleared without host write");

  sw_irq_a: assert property (
    q.swFlag && q.cfgBak[`BSO_BK_SWITCHOVER_IRQ_ENABLE] |=> !intN
  ) else $error("switchover interrupt not driven");

  bus_closed_a: assert property (
    q.pwr != bso_pkg::PWR_MAIN |-> !s_axi_awready && !s_axi_wready && !s_axi_arready && busOff
  ) else $error("bus open off main supply");

  clk_low_a: assert property (
    q.pwr == bso_pkg::PWR_BACKUP |-> clkoutLow
  ) else $error("clock output not held low");

  chg_off_a: assert property (
    q.pwr != bso_pkg::PWR_MAIN |-> !chargerOn
  ) else $error("charger on during backup");

  deb_time_a: assert property (
    q.pwr == bso_pkg::PWR_MAIN && $past(q.pwr) == bso_pkg::PWR_DEBOUNCE
      |-> $past(q.debCnt) == 12'(DEB_CYC - 1)
  ) else $error("debounce cut short");

  off_flag_a: assert property (
    modeKind(q.effMode) == bso_pkg::MODE_OFF |-> !q.swFlag && q.pwr == bso_pkg::PWR_MAIN
  ) else $error("flag or backup while switchover off");

  chg_follow_a: assert property (
    chargerOn == (q.pwr == bso_pkg::PWR_MAIN && q.cfgBak[`BSO_BK_TCE])
  ) else $error("charger output does not follow enable");

  por_irq_a: assert property (
    porSet && !q.powerLossFlag && q.cfgClk[`BSO_CK_POWER_LOSS_IRQ_ENABLE] |=> q.porIrqPend
  ) else $error("power-loss interrupt not raised");

  evt_pass_a: assert property (
    eventOut == $past(eventIn)
  ) else $error("event input not passed through");

  dsm_sel_a: assert property (
    q.pwr == bso_pkg::PWR_MAIN && q.effMode == 2'b01 && q.cfgBak[3:2] == 2'b01 &&
      !q.syncB[`BSO_S_VDD_GT_BAK] |=> q.pwr == bso_pkg::PWR_BACKUP && q.swFlag
  ) else $error("direct mode did not switch");

endmodule

`default_nettype wire

// File: bso_consts.svh
`ifndef BSO_CONSTS_SVH
`define BSO_CONSTS_SVH

// register indices; byte address is four times the index
`define BSO_IDX_STATUS 8'h0E
`define BSO_IDX_CLKCFG 8'h35
`define BSO_IDX_BAKCFG 8'h37

// status fields
`define BSO_ST_PLF 0
`define BSO_ST_SWF 3
`define BSO_ST_BUSY 7

// clock-output config fields
`define BSO_CK_WAKE 2
`define BSO_CK_POWER_LOSS_IRQ_ENABLE 3

// backup config fields
`define BSO_BK_TCR_LO 0
`define BSO_BK_BSM_LO 2
`define BSO_BK_FAST_EDGE_DETECT_ENABLE 4
`define BSO_BK_TCE 5
`define BSO_BK_SWITCHOVER_IRQ_ENABLE 6

// preset defaults
`define BSO_RST_CLKCFG 8'hC0
`define BSO_RST_BAKCFG 8'h10

// comparator slots in the synchroniser vector
`define BSO_S_VDD_GT_BAK 0
`define BSO_S_VDD_GT_THR 1
`define BSO_S_BAK_GT_THR 2
`define BSO_S_VDD_ON 3
`define BSO_S_DROP 4

// timing
`define BSO_CLK_MHZ 25
`define BSO_T_PREFR_MS 66
`define BSO_T_DSM_MS 2
`define BSO_T_LSM_US 15625
`define BSO_T_DEB_MIN_US 122
`define BSO_PREFR_CYC (`BSO_T_PREFR_MS * 1000 * `BSO_CLK_MHZ)
`define BSO_DSM_CYC (`BSO_T_DSM_MS * 1000 * `BSO_CLK_MHZ)
`define BSO_LSM_CYC (`BSO_T_LSM_US * `BSO_CLK_MHZ)
`define BSO_DEB_CYC (`BSO_T_DEB_MIN_US * `BSO_CLK_MHZ)

`define BSO_RESP_OKAY 2'h0
`define BSO_RESP_SLVERR 2'h2

`endif

// File: bso_pkg.sv
package bso_pkg;

  typedef enum logic [1:0] {
    PWR_MAIN = 2'b00,
    PWR_BACKUP = 2'b01,
    PWR_DEBOUNCE = 2'b10
  } bso_pwr_e;

  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_DIRECT = 2'b01,
    MODE_LEVEL = 2'b10
  } bso_mode_e;

  typedef struct packed {
    logic [4:0] syncA;
    logic [4:0] syncB;
    logic dropPrev;
    logic nvmBusy;
    logic [20:0] refreshCnt;
    logic [7:0] cfgClk;
    logic [7:0] cfgBak;
    logic powerLossFlag;
    logic porIrqPend;
    logic swFlag;
    logic clkWake;
    logic mainSeen;
    logic [1:0] effMode;
    logic [20:0] modeCnt;
    bso_pwr_e pwr;
    logic [11:0] debCnt;
    logic awHeld;
    logic wHeld;
    logic [7:0] awAddr;
    logic [7:0] wData;
    logic wStrb0;
    logic awRdy;
    logic wRdy;
    logic arRdy;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [1:0] rResp;
    logic [7:0] rData;
    logic intN;
    logic clkLow;
    logic busOff;
    logic chgOn;
    logic evtOut;
    logic bakSel;
    logic standby;
  } bso_state_s;

endpackage

// File: bso_supply_model.sv
`timescale 1ns/100ps
`default_nettype none

// supply side: comparators follow the commanded rail levels in millivolts
module bso_supply_model #(
  parameter int THR_MV = 2000,
  parameter int POR_MV = 1200,
  parameter int PRESENT_MV = 500,
  parameter logic [7:0] NVM_CLK = 8'h08,
  parameter logic [7:0] NVM_BAK = 8'h10
) (
  input wire logic [15:0] vddMv,
  input wire logic [15:0] bakMv,
  output logic vddAboveBackup,
  output logic vddAboveThr,
  output logic backupAboveThr,
  output logic vddPresent,
  output logic supplyDrop,
  output logic [7:0] nvmClkoutByte,
  output logic [7:0] nvmBackupByte
);
  // levels change only when the bench moves a rail, which it does right after an edge
  assign vddAboveBackup = vddMv > bakMv;
  assign vddAboveThr = vddMv > 16'(THR_MV);
  assign backupAboveThr = bakMv > 16'(THR_MV);
  assign vddPresent = vddMv > 16'(PRESENT_MV);
  assign supplyDrop = vddMv < 16'(POR_MV);
  assign nvmClkoutByte = NVM_CLK;
  assign nvmBackupByte = NVM_BAK;
endmodule

`default_nettype wire

// File: backup_switchover_por_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "bso_consts.svh"

module backup_switchover_por_ctrl_tb;
  localparam int PREFR = 20;
  localparam int DIRECT_SWITCHING = 8;
  localparam int LEVEL_SWITCHING = 12;
  localparam int DEB = 3050;
  localparam logic [7:0] A_ST = 8'(`BSO_IDX_STATUS * 4);
  localparam logic [7:0] A_CK = 8'(`BSO_IDX_CLKCFG * 4);
  localparam logic [7:0] A_BK = 8'(`BSO_IDX_BAKCFG * 4);
  logic core_clk, srst, awvalid, wvalid, bready, arvalid, rready, eventIn, otherIrq;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr, rd;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp, chargerRes;
  logic [15:0] vddMv, bakMv;
  logic vab, vat, bat, vpr, drp, intN, clkoutLow, busOff, chargerOn, fastEdgeEn;
  logic eventOut, backupSelect, backupStandby, clkoutWake, nvmBusy;
  logic [7:0] nvmCk, nvmBk;
  int failures = 0;
  int total_checks = 0;
  int waited;

  bso_supply_model sup_u (.vddMv(vddMv), .bakMv(bakMv), .vddAboveBackup(vab),
    .vddAboveThr(vat), .backupAboveThr(bat), .vddPresent(vpr), .supplyDrop(drp),
    .nvmClkoutByte(nvmCk), .nvmBackupByte(nvmBk));

  bso_ctrl #(.PREFR_CYC(PREFR), .DSM_CYC(DIRECT_SWITCHING), .LSM_CYC(LEVEL_SWITCHING)) dut_u (
    .core_clk(core_clk), .srst(srst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .vddAboveBackup(vab), .vddAboveThr(vat), .backupAboveThr(bat), .vddPresent(vpr),
    .supplyDrop(drp), .nvmClkoutByte(nvmCk), .nvmBackupByte(nvmBk), .eventIn(eventIn),
    .otherIrq(otherIrq), .intN(intN), .clkoutLow(clkoutLow), .busOff(busOff),
    .chargerOn(chargerOn), .chargerRes(chargerRes), .fastEdgeEn(fastEdgeEn),
    .eventOut(eventOut), .backupSelect(backupSelect), .backupStandby(backupStandby),
    .clkoutWake(clkoutWake), .nvmBusy(nvmBusy));

  initial begin
    core_clk = 0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // holds both write channels until each is taken, then waits for the response
  task automatic axw(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    int n;
    @(posedge core_clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h0, d};
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    r = 2'h3;
    for (n = 0; n < 100; n++) begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        break;
      end
    end
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b0;
    chk(32'(n < 100), 32'h1, "write answered");
  endtask

  task automatic axr(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
    int n;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    d = 8'h0;
    r = 2'h3;
    for (n = 0; n < 100; n++) begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata[7:0];
        r = rresp;
        break;
      end
    end
    arvalid <= 1'b0;
    rready <= 1'b0;
    chk(32'(n < 100), 32'h1, "read answered");
  endtask

  task automatic waitSel(input logic v, input int lim);
    waited = 0;
    while (backupSelect !== v && waited < lim) begin
      @(posedge core_clk);
      waited++;
    end
    chk(backupSelect, v, "supply select");
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (15000) @(posedge core_clk);
    failures++;
    stop_test;
  end

  initial begin
    srst = 1;
    {awvalid, wvalid, bready, arvalid, rready, eventIn, otherIrq} = '0;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    wstrb = 4'h0;
    vddMv = 16'd3300;
    bakMv = 16'd3000;
    tick(10);
    chk(fastEdgeEn, 1, "preset fast edge");
    chk(chargerOn, 0, "charger default");
    chk(nvmBusy, 1, "busy in reset");
    srst <= 1'b0;
    axr(A_ST, rd, rsp);
    chk(rd, 8'h81, "status after reset");
    waited = 0;
    while (nvmBusy !== 1'b0 && waited < PREFR + 10) begin
      tick(1);
      waited++;
    end
    chk(nvmBusy, 0, "refresh ends");
    axr(A_CK, rd, rsp);
    chk(rd, 8'h08, "mirror refreshed");
    axr(8'h00, rd, rsp);
    chk(rsp, `BSO_RESP_SLVERR, "unmapped read");
    $display("test reset done");
    axw(A_ST, 8'h00, rsp);
    axr(A_ST, rd, rsp);
    chk(rd, 8'h00, "power-loss cleared");
    vddMv <= 16'd1000;
    tick(3);
    vddMv <= 16'd3300;
    tick(8);
    chk(intN, 0, "power-loss irq");
    chk(backupSelect, 0, "off stays main");
    chk(backupStandby, 1, "standby while off");
    axr(A_ST, rd, rsp);
    chk(rd, 8'h01, "power-loss set");
    axw(A_ST, 8'h00, rsp);
    tick(3);
    chk(intN, 1, "irq released");
    $display("test power loss done");
    vddMv <= 16'd2500;
    for (int m = 0; m < 2; m++) begin
      axw(A_BK, m ? 8'h18 : 8'h10, rsp);
      tick(DIRECT_SWITCHING + LEVEL_SWITCHING + 10);
      chk(backupSelect, 0, "mode off");
      axr(A_ST, rd, rsp);
      chk(rd, 8'h00, "flag off");
    end
    $display("test disabled done");
    vddMv <= 16'd3300;
    axw(A_CK, 8'h0C, rsp);
    axw(A_BK, 8'h75, rsp);
    chk(rsp, `BSO_RESP_OKAY, "config write okay");
    tick(2);
    chk(chargerOn, 1, "charger on");
    chk(chargerRes, 2'h1, "resistor field");
    vddMv <= 16'd2500;
    waitSel(1, DIRECT_SWITCHING + 10);
    chk(backupStandby, 0, "standby left");
    tick(2);
    chk(busOff, 1, "bus isolated");
    chk(clkoutLow, 1, "clock out low");
    chk(chargerOn, 0, "charger forced off");
    chk(intN, 0, "switchover irq");
    eventIn <= 1'b1;
    tick(2);
    chk(eventOut, 1, "event on backup");
    vddMv <= 16'd3300;
    waitSel(0, DEB + 20);
    chk(32'(waited >= DEB), 32'h1, "debounce length");
    tick(2);
    chk(busOff, 0, "bus back");
    chk(clkoutWake, 1, "clock wake");
    axr(A_ST, rd, rsp);
    chk(rd, 8'h08, "switch flag");
    axw(A_ST, 8'h00, rsp);
    tick(3);
    chk(intN, 1, "irq cleared");
    chk(clkoutWake, 0, "wake cleared");
    $display("test direct done");
    axw(A_BK, 8'h10, rsp);
    axw(A_BK, 8'h1C, rsp);
    vddMv <= 16'd2500;
    tick(LEVEL_SWITCHING + 10);
    chk(backupSelect, 0, "level main above thr");
    vddMv <= 16'd1800;
    bakMv <= 16'd1500;
    tick(10);
    chk(backupSelect, 0, "level weak backup");
    bakMv <= 16'd3000;
    waitSel(1, 20);
    vddMv <= 16'd3300;
    waitSel(0, DEB + 20);
    $display("test level done");
    stop_test;
  end
endmodule

`default_nettype wire
